// >>> src/dmactc_channel.sv
// DMA channel transfer control: control bits, address stepping, transfer
// count, end interrupt and an AHB-Lite register slave.
// Assumes one 100 MHz clock; xfer_req_i is asynchronous to it.
`timescale 1ns/1ps
// What this block does
// - Short mode, direction 0: memory address rises 1 per byte, 2 per word.
// - Short mode, direction 1: memory address falls 1 per byte, 2 per word.
// - Full mode, source direction 0: source address rises 1 or 2 when stepping enabled, else fixed.
// - Full mode, stepping enabled, direction 1: source address falls 1 or 2.
// - Transfers only while transfer enable is 1; size bit picks byte or word.
// - Transfer interrupt enable passes or suppresses the end interrupt.
// - Interrupt raised when transfer enable falls with interrupt enable and the end mask bit set.
module dmactc_channel
  import dmactc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Transfer request pin and transfer strobe
  input wire logic xfer_req_i,
  output logic xfer_stb_o,
  output logic [ADDR_W-1:0] xfer_addr_o,
  output logic xfer_word_o,
  // Interrupt to the CPU
  output logic irq_o
);

  // Bus state
  logic ap_valid_q, ap_valid_d;
  logic ap_write_q, ap_write_d;
  logic [OFF_W-1:0] ap_off_q, ap_off_d;
  logic [31:0] hrdata_q, hrdata_d;
  // Channel state
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [ADDR_W-1:0] mem_q, mem_d;
  logic [ADDR_W-1:0] src_q, src_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] rld_q, rld_d;
  logic [IRQ_W-1:0] stat_q, stat_d;
  logic [IRQ_W-1:0] mask_q, mask_d;
  logic stb_q, stb_d;
  logic [ADDR_W-1:0] xaddr_q, xaddr_d;
  logic xword_q, xword_d;
  // Request synchroniser
  logic req_s1_q, req_s2_q, req_s3_q;
  // Decodes
  logic ap_take, wr_en, req_rise, fire, full, last;
  logic end_evt;
  logic [ADDR_W-1:0] mem_step, src_step;
  logic [31:0] rd_mux;
  logic [IRQ_W-1:0] w1c;
  dmactc_mode_t mode;

  // Register offset match; the caller checks the upper address bits
  function automatic logic hit_f(input logic [OFF_W-1:0] off, input logic [OFF_W-1:0] reg_off);
    return off == reg_off;
  endfunction

  // Request pin crosses in; the second and third stages feed the edge detector
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= xfer_req_i;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // Common decodes
  assign ap_take = hsel_i & htrans_i[HTRANS_ACT] & hready_i;
  assign wr_en = ap_valid_q & ap_write_q;
  assign req_rise = req_s2_q & ~req_s3_q;
  assign full = ctrl_q[BIT_FULL];
  assign fire = req_rise & ctrl_q[BIT_TE];
  assign last = cnt_q <= CNT_ONE;
  assign mode = dmactc_mode_f(ctrl_q[BIT_RPT], ctrl_q[BIT_IE]);

  // Memory address steps in short mode only
  dmactc_addr_step u_mem_step (
    .addr_i(mem_q),
    .enable_i(~full),
    .dir_i(ctrl_q[BIT_DIR]),
    .word_i(ctrl_q[BIT_SIZE]),
    .next_o(mem_step)
  );

  // Source address steps in full mode when its step enable is set
  dmactc_addr_step u_src_step (
    .addr_i(src_q),
    .enable_i(full & ctrl_q[BIT_SRC_EN]),
    .dir_i(ctrl_q[BIT_SRC_DIR]),
    .word_i(ctrl_q[BIT_SIZE]),
    .next_o(src_step)
  );

  // Read mux, sampled in the address phase so hrdata comes from a flop
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr_i[31:OFF_W] == 24'h00_0000) begin
      if (hit_f(haddr_i[OFF_W-1:0], OFF_CTRL)) begin
        rd_mux[CTRL_W-1:0] = ctrl_q;
      end else if (hit_f(haddr_i[OFF_W-1:0], OFF_MEM_ADDR)) begin
        rd_mux[ADDR_W-1:0] = mem_q;
      end else if (hit_f(haddr_i[OFF_W-1:0], OFF_SRC_ADDR)) begin
        rd_mux[ADDR_W-1:0] = src_q;
      end else if (hit_f(haddr_i[OFF_W-1:0], OFF_COUNT)) begin
        rd_mux[CNT_W-1:0] = cnt_q;
      end else if (hit_f(haddr_i[OFF_W-1:0], OFF_IRQ_STAT)) begin
        rd_mux[IRQ_W-1:0] = stat_q;
      end else if (hit_f(haddr_i[OFF_W-1:0], OFF_IRQ_MASK)) begin
        rd_mux[IRQ_W-1:0] = mask_q;
      end else if (hit_f(haddr_i[OFF_W-1:0], OFF_MODE)) begin
        rd_mux[1:0] = mode;
      end
    end
  end

  // Bus address phase capture; zero wait states, so hready is ours
  always_comb begin
    ap_valid_d = ap_valid_q;
    ap_write_d = ap_write_q;
    ap_off_d = ap_off_q;
    hrdata_d = hrdata_q;
    if (hready_i) begin
      ap_valid_d = ap_take & (haddr_i[31:OFF_W] == 24'h00_0000);
      ap_write_d = hwrite_i;
      ap_off_d = haddr_i[OFF_W-1:0];
      if (ap_take && !hwrite_i) begin
        hrdata_d = rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_off_q <= OFF_CTRL;
      hrdata_q <= 32'h0000_0000;
    end else begin
      ap_valid_q <= ap_valid_d;
      ap_write_q <= ap_write_d;
      ap_off_q <= ap_off_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Channel state: hardware end-of-count clears enable after a software
  // write, but software address and count writes win over a step
  always_comb begin
    ctrl_d = ctrl_q;
    mem_d = mem_q;
    src_d = src_q;
    cnt_d = cnt_q;
    rld_d = rld_q;
    mask_d = mask_q;
    w1c = IRQ_RST;
    if (wr_en && hit_f(ap_off_q, OFF_CTRL)) begin
      ctrl_d = hwdata_i[CTRL_W-1:0];
    end
    if (fire) begin
      mem_d = mem_step;
      src_d = src_step;
      if (!last) begin
        cnt_d = cnt_q - CNT_ONE;
      end else if (!full && mode == DMACTC_MODE_REPEAT) begin
        cnt_d = rld_q;
      end else begin
        cnt_d = CNT_RST;
        ctrl_d[BIT_TE] = 1'b0;
      end
    end
    if (wr_en && hit_f(ap_off_q, OFF_MEM_ADDR)) begin
      mem_d = hwdata_i[ADDR_W-1:0];
    end
    if (wr_en && hit_f(ap_off_q, OFF_SRC_ADDR)) begin
      src_d = hwdata_i[ADDR_W-1:0];
    end
    if (wr_en && hit_f(ap_off_q, OFF_COUNT)) begin
      cnt_d = hwdata_i[CNT_W-1:0];
      rld_d = hwdata_i[CNT_W-1:0];
    end
    if (wr_en && hit_f(ap_off_q, OFF_IRQ_MASK)) begin
      mask_d = hwdata_i[IRQ_W-1:0];
    end
    if (wr_en && hit_f(ap_off_q, OFF_IRQ_STAT)) begin
      w1c = hwdata_i[IRQ_W-1:0];
    end
  end

  // End event only with the interrupt enable set; set wins over clear
  assign end_evt = ctrl_q[BIT_TE] & ~ctrl_d[BIT_TE] & ctrl_d[BIT_IE];
  always_comb begin
    stat_d = stat_q & ~w1c;
    stat_d[IRQ_END] = stat_d[IRQ_END] | end_evt;
    stat_d[IRQ_STEP] = stat_d[IRQ_STEP] | fire;
  end

  // Transfer strobe toward the bus cycle logic
  always_comb begin
    stb_d = fire;
    xaddr_d = xaddr_q;
    xword_d = xword_q;
    if (fire) begin
      xaddr_d = full ? src_q : mem_q;
      xword_d = ctrl_q[BIT_SIZE];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q <= CTRL_RST;
      mem_q <= ADDR_RST;
      src_q <= ADDR_RST;
      cnt_q <= CNT_RST;
      rld_q <= CNT_RST;
      stat_q <= IRQ_RST;
      mask_q <= IRQ_RST;
      stb_q <= 1'b0;
      xaddr_q <= ADDR_RST;
      xword_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mem_q <= mem_d;
      src_q <= src_d;
      cnt_q <= cnt_d;
      rld_q <= rld_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      stb_q <= stb_d;
      xaddr_q <= xaddr_d;
      xword_q <= xword_d;
    end
  end

  // Outputs; slave never stalls and always answers OKAY
  assign hrdata_o = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign xfer_stb_o = stb_q;
  assign xfer_addr_o = xaddr_q;
  assign xfer_word_o = xword_q;
  assign irq_o = |(stat_q & mask_q);

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_short_fire;
    fire && !full && !wr_en;
  endsequence

  sequence s_full_fire;
    fire && full && ctrl_q[BIT_SRC_EN] && !wr_en;
  endsequence

  property p_short_up;
    s_short_fire and !ctrl_q[BIT_DIR] |=>
      mem_q == $past(mem_q) + ($past(ctrl_q[BIT_SIZE]) ? STEP_WORD : STEP_BYTE);
  endproperty
  a_short_up: assert property (p_short_up) else $error("memory address not raised");

  property p_short_down;
    s_short_fire and ctrl_q[BIT_DIR] |=>
      mem_q == $past(mem_q) - ($past(ctrl_q[BIT_SIZE]) ? STEP_WORD : STEP_BYTE);
  endproperty
  a_short_down: assert property (p_short_down) else $error("memory address not lowered");

  property p_src_up;
    s_full_fire and !ctrl_q[BIT_SRC_DIR] |=>
      src_q == $past(src_q) + ($past(ctrl_q[BIT_SIZE]) ? STEP_WORD : STEP_BYTE);
  endproperty
  a_src_up: assert property (p_src_up) else $error("source address not raised");

  property p_src_hold;
    fire && full && !ctrl_q[BIT_SRC_EN] && !wr_en |=> $stable(src_q);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source address moved");

  property p_src_down;
    s_full_fire and ctrl_q[BIT_SRC_DIR] |=>
      src_q == $past(src_q) - ($past(ctrl_q[BIT_SIZE]) ? STEP_WORD : STEP_BYTE);
  endproperty
  a_src_down: assert property (p_src_down) else $error("source address not lowered");

  property p_only_enabled;
    xfer_stb_o |-> $past(ctrl_q[BIT_TE]) && xfer_word_o == $past(ctrl_q[BIT_SIZE]);
  endproperty
  a_only_enabled: assert property (p_only_enabled) else $error("transfer while disabled");

  property p_end_gated;
    $rose(stat_q[IRQ_END]) |-> $fell(ctrl_q[BIT_TE]) && ctrl_q[BIT_IE];
  endproperty
  a_end_gated: assert property (p_end_gated) else $error("end interrupt not gated");

  property p_end_raise;
    $fell(ctrl_q[BIT_TE]) && ctrl_q[BIT_IE] && mask_q[IRQ_END] |->
      stat_q[IRQ_END] && irq_o;
  endproperty
  a_end_raise: assert property (p_end_raise) else $error("end interrupt missing");

  property p_repeat_keeps;
    fire && last && !full && ctrl_q[BIT_RPT] && !ctrl_q[BIT_IE] && !wr_en |=>
      ctrl_q[BIT_TE] && cnt_q == rld_q;
  endproperty
  a_repeat_keeps: assert property (p_repeat_keeps) else $error("repeat mode stopped");

endmodule

// >>> src/dmactc_pkg.sv
// Package for the DMA channel transfer control block: register map,
// control field positions, step sizes, operating modes and decoders.
// Assumes a 32-bit AHB-Lite slave port and 16-bit channel addresses.
package dmactc_pkg;

  // Widths of the channel datapath
  localparam int ADDR_W = 16;
  localparam int CNT_W = 16;
  localparam int CTRL_W = 8;
  localparam int IRQ_W = 2;

  // Register byte offsets (bits of haddr above OFF_W must be zero)
  localparam int OFF_W = 8;
  localparam logic [OFF_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [OFF_W-1:0] OFF_MEM_ADDR = 8'h04;
  localparam logic [OFF_W-1:0] OFF_SRC_ADDR = 8'h08;
  localparam logic [OFF_W-1:0] OFF_COUNT = 8'h0C;
  localparam logic [OFF_W-1:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [OFF_W-1:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [OFF_W-1:0] OFF_MODE = 8'h18;

  // Control register fields
  localparam int BIT_TE = 7;       // transfer_enable_bit
  localparam int BIT_SIZE = 6;     // transfer_size_sel
  localparam int BIT_DIR = 5;      // step_direction_bit
  localparam int BIT_RPT = 4;      // repeat_enable_bit
  localparam int BIT_IE = 3;       // transfer_irq_enable
  localparam int BIT_FULL = 2;     // full address mode select
  localparam int BIT_SRC_EN = 1;   // source_step_enable
  localparam int BIT_SRC_DIR = 0;  // source_step_direction

  // Interrupt status / mask fields
  localparam int IRQ_END = 0;
  localparam int IRQ_STEP = 1;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // Address step per transfer
  localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002;

  // AHB transfer type bit that marks NONSEQ/SEQ
  localparam int HTRANS_ACT = 1;

  // Short address mode operating modes
  typedef enum logic [1:0] {
    DMACTC_MODE_IO,
    DMACTC_MODE_REPEAT,
    DMACTC_MODE_IDLE
  } dmactc_mode_t;

  // Mode from repeat enable and transfer interrupt enable
  function automatic dmactc_mode_t dmactc_mode_f(input logic rpt, input logic ie);
    if (!rpt) begin
      return DMACTC_MODE_IO;
    end else if (!ie) begin
      return DMACTC_MODE_REPEAT;
    end
    return DMACTC_MODE_IDLE;
  endfunction

  // Step size from transfer size select
  function automatic logic [ADDR_W-1:0] dmactc_step_f(input logic word);
    return word ? STEP_WORD : STEP_BYTE;
  endfunction

endpackage

// >>> src/dmactc_addr_step.sv
// Address stepper: next value of one channel address register.
// Assumes the caller decides when a transfer has actually happened.
`timescale 1ns/1ps
module dmactc_addr_step
  import dmactc_pkg::*;
(
  // Current state
  input wire logic [ADDR_W-1:0] addr_i,
  // Step control
  input wire logic enable_i,
  input wire logic dir_i,
  input wire logic word_i,
  // Result
  output logic [ADDR_W-1:0] next_o
);

  // Held, raised or lowered by one transfer's width
  always_comb begin
    if (!enable_i) begin
      next_o = addr_i;
    end else if (dir_i) begin
      next_o = addr_i - dmactc_step_f(word_i);
    end else begin
      next_o = addr_i + dmactc_step_f(word_i);
    end
  end

endmodule

// >>> verification/dmactc_partner.sv
// Far-side model: the peripheral that raises the transfer request pin.
// Assumes one fire pulse from the bench per wanted transfer.
`timescale 1ns/1ps
module dmactc_partner (
  // Clock and command
  input wire logic core_clk_i,
  input wire logic fire_i,
  // Request pin
  output logic req_o
);
  logic [2:0] cnt_q = 3'h0;
  // Three cycles high, then three low, so the synchroniser never merges two rises
  always @(posedge core_clk_i) begin
    if (fire_i && cnt_q == 3'h0) begin
      cnt_q <= 3'h6;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign req_o = (cnt_q > 3'h3);
endmodule

// >>> verification/test_dma_channel_transfer_control.sv
// Testbench for the DMA channel: AHB-Lite master tasks, request model, checks.
// Assumes zero wait-state slave and the partner model for the request pin.
`timescale 1ns/1ps
module test_dma_channel_transfer_control import dmactc_pkg::*; ;
  localparam int TE = 1 << BIT_TE;
  localparam int IE = 1 << BIT_IE;
  localparam int RPT = 1 << BIT_RPT;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic fire = 1'b0;
  logic [31:0] hrdata, x;
  logic hready, hresp, stb, xword, irq, req;
  logic [ADDR_W-1:0] xaddr;
  int mismatches = 0;
  int cmp_count = 0;
  integer seed = 32'h44f8ec78;
  int ma, sa, st, em, es, c;
  logic sz, dr, fu, se, sd;

  always #5 core_clk_i = ~core_clk_i;

  dmactc_channel dmactc_channel_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .xfer_req_i(req), .xfer_stb_o(stb),
    .xfer_addr_o(xaddr), .xfer_word_o(xword), .irq_o(irq));
  dmactc_partner dmactc_partner_inst (.core_clk_i(core_clk_i), .fire_i(fire), .req_o(req));

  task final_report;
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; read data taken at the data phase edge
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge core_clk_i);
    while (hready !== 1'b1) @(posedge core_clk_i);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk_i);
    while (hready !== 1'b1) @(posedge core_clk_i);
    rd = hrdata;
  endtask

  task wr(input logic [OFF_W-1:0] off, input logic [31:0] d);
    ahb(1'b1, {{(32-OFF_W){1'b0}}, off}, d, x);
  endtask

  task rdc(input logic [OFF_W-1:0] off, input logic [31:0] exp);
    ahb(1'b0, {{(32-OFF_W){1'b0}}, off}, 32'h0, x);
    chk(x, exp);
  endtask

  // Fire one request and look for the strobe at settled negedges
  task xfer(input logic exp_stb, input logic [15:0] exp_addr, input logic exp_word);
    logic seen;
    seen = 1'b0;
    @(posedge core_clk_i);
    fire <= 1'b1;
    @(posedge core_clk_i);
    fire <= 1'b0;
    repeat (12) begin
      @(negedge core_clk_i);
      if (stb === 1'b1 && !seen) begin
        seen = 1'b1;
        chk(32'(xaddr), 32'(exp_addr));
        chk(32'(xword), 32'(exp_word));
      end
    end
    chk(32'(seen), 32'(exp_stb));
    repeat (6) @(posedge core_clk_i);
  endtask

  // Watchdog sized well above the few thousand cycles the run needs
  initial begin
    #500000;
    mismatches++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_MODE, 32'h0);
    // Unmapped write must not land anywhere
    ahb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF, x);
    ahb(1'b0, 32'h0000_0100, 32'h0, x);
    chk(x, 32'h0);
    rdc(OFF_CTRL, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, m << BIT_IE);
      rdc(OFF_MODE, m < 2 ? 0 : (m == 2 ? 1 : 2));
    end
    // Enable low: request dropped, address untouched
    wr(OFF_CTRL, 32'h0);
    wr(OFF_MEM_ADDR, 32'h0000_1234);
    xfer(1'b0, 16'h0, 1'b0);
    rdc(OFF_MEM_ADDR, 32'h0000_1234);
    // Every size, direction and addressing combination with random start addresses
    wr(OFF_IRQ_MASK, 32'h0);
    for (int k = 0; k < 32; k++) begin
      {sz, dr, fu, se, sd} = 5'(k);
      ma = $random(seed) & 32'hFFFF;
      sa = $random(seed) & 32'hFFFF;
      wr(OFF_MEM_ADDR, ma);
      wr(OFF_SRC_ADDR, sa);
      wr(OFF_COUNT, 32'h2);
      c = TE | (sz << BIT_SIZE) | (dr << BIT_DIR) | (fu << BIT_FULL);
      wr(OFF_CTRL, c | (se << BIT_SRC_EN) | (sd << BIT_SRC_DIR));
      st = sz ? 2 : 1;
      em = ma;
      es = sa;
      if (fu) begin
        if (se) es = (sd ? sa - st : sa + st) & 32'hFFFF;
      end else begin
        em = (dr ? ma - st : ma + st) & 32'hFFFF;
      end
      xfer(1'b1, fu ? sa[15:0] : ma[15:0], sz);
      rdc(OFF_MEM_ADDR, em);
      rdc(OFF_SRC_ADDR, es);
      rdc(OFF_IRQ_STAT, 32'h2);
      @(negedge core_clk_i);
      chk(32'(irq), 32'h0);
      wr(OFF_IRQ_STAT, 32'h3);
    end
    // Last transfer ends the run; end interrupt per enable and mask
    for (int e = 0; e < 4; e++) begin
      wr(OFF_IRQ_STAT, 32'h3);
      wr(OFF_IRQ_MASK, e & 1);
      wr(OFF_MEM_ADDR, 32'h0000_0100);
      wr(OFF_COUNT, 32'h1);
      wr(OFF_CTRL, TE | ((e >> 1) << BIT_IE));
      xfer(1'b1, 16'h0100, 1'b0);
      rdc(OFF_CTRL, (e >> 1) << BIT_IE);
      ahb(1'b0, 32'(OFF_IRQ_STAT), 32'h0, x);
      chk(x & 32'h1, e >> 1);
      @(negedge core_clk_i);
      chk(32'(irq), (e >> 1) & e & 1);
      wr(OFF_IRQ_STAT, 32'h1);
      @(negedge core_clk_i);
      chk(32'(irq), 32'h0);
    end
    // Software clearing of the enable also raises the end event
    wr(OFF_IRQ_STAT, 32'h3);
    wr(OFF_CTRL, TE | IE);
    wr(OFF_CTRL, IE);
    rdc(OFF_IRQ_STAT, 32'h1);
    // Repeat mode keeps the enable after the last count
    wr(OFF_MEM_ADDR, 32'h0000_0200);
    wr(OFF_COUNT, 32'h1);
    wr(OFF_CTRL, TE | RPT);
    xfer(1'b1, 16'h0200, 1'b0);
    rdc(OFF_CTRL, TE | RPT);
    rdc(OFF_MODE, 32'h1);
    // Mid-run reset: enable and status return to zero
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_IRQ_STAT, 32'h0);
    final_report();
  end
endmodule
